// *** dv/adc_conversion_i2c_readout_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_i2c_readout_test;
   logic mclk, rst, scl, mOe, sdaOut, sdaOe, convBusy, sleepMode, dataOutMode;
   logic [17:0] modSum, calOffset;
   int num_errors, tests_run;
   wire sda = ~(sdaOe | mOe);
   adcq_master m (.mclk(mclk), .sda(sda), .scl(scl), .sdaOe(mOe));
   adcq_i2c_readout #(.POR_CYCLES(24'h000014), .CONV_CYCLES(24'h0000c8)) uut (.mclk(mclk),
      .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .modSum(modSum),
      .calOffset(calOffset), .convBusy(convBusy), .sleepMode(sleepMode),
      .dataOutMode(dataOutMode));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [15:0] code(input logic [17:0] ms, input logic [17:0] of);
      int d;
      d = $signed(ms) - $signed(of);
      if (d > 32767) d = 32767;
      if (d < -32768) d = -32768;
      return 16'(d) ^ 16'h8000;
   endfunction
   task automatic wait_on(input int s);
      int n;
      n = 0;
      while ((s ? sleepMode : convBusy) !== 1'b1 && n < 1000) begin
         @(negedge mclk);
         n++;
      end
      chk("mode", 16'h0001, s ? sleepMode : convBusy);
   endtask
   task automatic addr(input logic [7:0] a, output logic ack);
      logic [7:0] q;
      m.start();
      m.xfer(a, q);
      m.bitx(1'b1, ack);
   endtask
   task automatic rd_word(output logic [15:0] w);
      logic a;
      m.xfer(8'hff, w[15:8]);
      m.bitx(1'b0, a);
      m.xfer(8'hff, w[7:0]);
      m.bitx(1'b1, a);
   endtask
   task automatic t_busy_nak;
      logic a;
      wait_on(0);
      addr(8'h29, a);
      chk("busy ack", 16'h0001, a);
      m.stop();
   endtask
   task automatic t_refuse;
      logic [7:0] t[3] = '{8'h2b, 8'h28, 8'h49};
      logic a;
      wait_on(1);
      foreach (t[i]) begin
         addr(t[i], a);
         chk("other ack", 16'h0001, a);
         m.stop();
         chk("sleep", 16'h0001, sleepMode);
      end
   endtask
   task automatic t_reads;
      logic [17:0] ms[5] = '{18'h00064, 18'h3fffb, 18'h1ffff, 18'h20000, 18'h0012c};
      logic [17:0] of[5] = '{18'h00000, 18'h00000, 18'h00000, 18'h00000, 18'h00190};
      logic a;
      logic [15:0] w;
      foreach (ms[i]) begin
         modSum = ms[i];
         calOffset = of[i];
         wait_on(1);
         addr(8'h29, a);
         chk("discard ack", 16'h0000, a);
         m.xfer(8'hff, w[15:8]);
         m.bitx(1'b1, a);
         m.stop();
         chk("discard", 16'h0001, convBusy);
         wait_on(1);
         addr(8'h29, a);
         chk("ack", 16'h0000, a);
         rd_word(w);
         chk("word", code(ms[i], of[i]), w);
         m.hw(4);
         chk("busy after 16", 16'h0001, convBusy);
         m.stop();
      end
   endtask
   task automatic t_rstart;
      logic a;
      logic [7:0] q;
      logic [15:0] w;
      modSum = 18'h00abc;
      wait_on(1);
      addr(8'h29, a);
      m.xfer(8'hff, q);
      m.bitx(1'b1, a);
      chk("hold out", 16'h0001, dataOutMode);
      addr(8'h29, a);
      chk("rstart ack", 16'h0000, a);
      rd_word(w);
      chk("rstart word", code(18'h00abc, 18'h00190), w);
      m.stop();
   endtask
   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge mclk);
      num_errors++;
      end_sim();
   end
   initial begin
      rst = 1'b1;
      modSum = 18'h00000;
      calOffset = 18'h00000;
      num_errors = 0;
      tests_run = 0;
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      t_busy_nak();
      t_refuse();
      t_reads();
      t_rstart();
      end_sim();
   end
endmodule
bind adcq_i2c_readout adcq_readout_props #(.POR_CYCLES(POR_CYCLES), .CONV_CYCLES(CONV_CYCLES))
   chk (.mclk(mclk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .modSum(modSum), .calOffset(calOffset), .convBusy(convBusy), .sleepMode(sleepMode),
   .dataOutMode(dataOutMode));
`default_nettype wire

// *** dv/adcq_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcq_master (
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic sdaOe
);
   initial begin
      scl = 1'b1;
      sdaOe = 1'b0;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // start or repeated start
   task automatic start;
      hw(2);
      sdaOe = 1'b0;
      hw(2);
      scl = 1'b1;
      hw(2);
      sdaOe = 1'b1;
      hw(2);
      scl = 1'b0;
   endtask
   task automatic stop;
      hw(2);
      sdaOe = 1'b1;
      hw(2);
      scl = 1'b1;
      hw(2);
      sdaOe = 1'b0;
      hw(4);
   endtask
   // one clock: drive b in low phase, sample in high phase
   task automatic bitx(input logic b, output logic r);
      hw(2);
      sdaOe = ~b;
      hw(2);
      scl = 1'b1;
      hw(3);
      r = sda;
      hw(1);
      scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
   endtask
endmodule
`default_nettype wire

// *** dv/adcq_readout_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcq_readout_props #(
   parameter int POR_CYCLES = 20,
   parameter int CONV_CYCLES = 200
) (
   input wire mclk,
   input wire rst,
   input wire sclIn,
   input wire sdaIn,
   input wire sdaOut,
   input wire sdaOe,
   input wire [17:0] modSum,
   input wire [17:0] calOffset,
   input wire convBusy,
   input wire sleepMode,
   input wire dataOutMode
);
   localparam int PLO = POR_CYCLES - 4;
   localparam int PHI = POR_CYCLES + 8;
   localparam int CLO = CONV_CYCLES - 10;
   localparam int CHI = CONV_CYCLES + 10;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   sda_pull_a: assert property (sdaOut == 1'b0) else $error("sda driven high");
   busy_quiet_a: assert property (convBusy |-> !sdaOe) else $error("sda pulled in conversion");
   modes_one_a: assert property ($onehot0({convBusy, sleepMode, dataOutMode}))
      else $error("two modes at once");
   sleep_entry_a: assert property ($rose(sleepMode) |-> $past(convBusy) || $past(convBusy, 2))
      else $error("sleep not after conversion");
   out_entry_a: assert property ($rose(dataOutMode) |-> $past(sleepMode) || $past(sleepMode, 2))
      else $error("output not after sleep");
   conv_restart_a: assert property ($fell(dataOutMode) |-> ##[0:3] convBusy)
      else $error("no conversion after output");
   sleep_hold_a: assert property (sleepMode |=> sleepMode || dataOutMode)
      else $error("sleep left without read");
   reset_clear_a: assert property (disable iff (1'b0) rst |=>
      !sdaOe && !convBusy && !sleepMode && !dataOutMode) else $error("outputs not cleared");
   por_span_a: assert property ($fell(rst) |-> ##[PLO:PHI] $rose(convBusy))
      else $error("por interval wrong");
   conv_span_a: assert property ($rose(convBusy) |-> ##[CLO:CHI] $fell(convBusy))
      else $error("conversion length wrong");
   cover property ($rose(dataOutMode));
   cover property (sleepMode && $rose(sdaOe));
   cover property ($fell(dataOutMode));
endmodule
`default_nettype wire

// *** hdl/adcq_i2c_readout.v ***
`timescale 1ns/1ns
`default_nettype none
`include "adcq_map.vh"
module adcq_i2c_readout #(
   parameter [`ADCQ_TMR_W-1:0] POR_CYCLES =
      `ADCQ_POR_US * `ADCQ_CLK_KHZ / `ADCQ_US_PER_MS,
   parameter [`ADCQ_TMR_W-1:0] CONV_CYCLES =
      `ADCQ_CONV_US * `ADCQ_CLK_KHZ / `ADCQ_US_PER_MS
) (
   input wire mclk,
   input wire rst,
   input wire sclIn,
   input wire sdaIn,
   output reg sdaOut,
   output reg sdaOe,
   input wire [`ADCQ_RAW_W-1:0] modSum,
   input wire [`ADCQ_RAW_W-1:0] calOffset,
   output reg convBusy,
   output reg sleepMode,
   output reg dataOutMode
);
   // saturating result: difference clamped to 16 bits
   function [15:0] adcqClamp;
      input [`ADCQ_RAW_W:0] v;
      begin
         if (v[`ADCQ_RAW_W:15] == {(`ADCQ_RAW_W-14){1'b0}} ||
             v[`ADCQ_RAW_W:15] == {(`ADCQ_RAW_W-14){1'b1}}) begin
            adcqClamp = v[15:0];
         end else if (v[`ADCQ_RAW_W]) begin
            adcqClamp = `ADCQ_CODE_MIN;
         end else begin
            adcqClamp = `ADCQ_CODE_MAX;
         end
      end
   endfunction

   // bus line synchroniser output
   wire [1:0] busSync;
   wire sclS;
   wire sdaS;
   assign sclS = busSync[1];
   assign sdaS = busSync[0];

   // scl is only ever sampled, never driven
   adcq_sync #(
      .W(2)
   ) uSync (
      .mclk(mclk),
      .rst(rst),
      .d({sclIn, sdaIn}),
      .q(busSync)
   );

   // power-on reset interval and conversion interval
   reg porKick_r;
   reg convKick_r;
   wire porBusy;
   wire porDone;
   wire convTmrBusy;
   wire convDone;

   adcq_timer #(
      .CYCLES(POR_CYCLES)
   ) uPor (
      .mclk(mclk),
      .rst(rst),
      .start(porKick_r),
      .busy(porBusy),
      .done(porDone)
   );

   adcq_timer #(
      .CYCLES(CONV_CYCLES)
   ) uConv (
      .mclk(mclk),
      .rst(rst),
      .start(convKick_r),
      .busy(convTmrBusy),
      .done(convDone)
   );

   // edge detection on synchronised lines
   reg sclPrev_r;
   reg sdaPrev_r;
   wire sclRise;
   wire sclFall;
   wire startCond;
   wire stopCond;
   assign sclRise = sclS & ~sclPrev_r;
   assign sclFall = ~sclS & sclPrev_r;
   assign startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
   assign stopCond = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

   // offset-corrected, clamped, sign-flipped result
   wire [`ADCQ_RAW_W:0] diff;
   wire [15:0] code;
   assign diff = {modSum[`ADCQ_RAW_W-1], modSum} -
      {calOffset[`ADCQ_RAW_W-1], calOffset};
   assign code = adcqClamp(diff) ^ `ADCQ_SIGN_FLIP;

   reg [1:0] state_r;
   reg [2:0] phase_r;
   reg [3:0] bitCnt_r;
   reg [7:0] addrSh_r;
   reg [15:0] result_r;
   reg [15:0] txSh_r;
   reg byteSel_r;
   reg validRead_r;

   wire addrHit;
   wire readReady;
   assign addrHit = (addrSh_r[7:1] == `ADCQ_SLAVE_ADDR) &&
      (addrSh_r[0] == `ADCQ_READ_BIT);
   assign readReady = (state_r == `ADCQ_ST_SLEEP) ||
      (state_r == `ADCQ_ST_OUT);

   always @(posedge mclk) begin
      if (rst) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclPrev_r <= sclS;
         sdaPrev_r <= sdaS;
      end
   end

   // operating state and slave serial engine
   always @(posedge mclk) begin
      if (rst) begin
         state_r <= `ADCQ_ST_POR;
         phase_r <= `ADCQ_PH_IDLE;
         bitCnt_r <= 4'h0;
         addrSh_r <= 8'h00;
         result_r <= 16'h0000;
         txSh_r <= 16'h0000;
         byteSel_r <= 1'b0;
         validRead_r <= 1'b0;
         porKick_r <= 1'b1;
         convKick_r <= 1'b0;
         sdaOut <= 1'b0;
         sdaOe <= 1'b0;
         convBusy <= 1'b0;
         sleepMode <= 1'b0;
         dataOutMode <= 1'b0;
      end else begin
         porKick_r <= 1'b0;
         convKick_r <= 1'b0;
         sdaOut <= 1'b0;
         convBusy <= (state_r == `ADCQ_ST_CONV);
         sleepMode <= (state_r == `ADCQ_ST_SLEEP);
         dataOutMode <= (state_r == `ADCQ_ST_OUT);

         // conversion sequencing
         case (state_r)
            `ADCQ_ST_POR: begin
               if (porDone) begin
                  state_r <= `ADCQ_ST_CONV;
                  convKick_r <= 1'b1;
               end
            end
            `ADCQ_ST_CONV: begin
               if (convDone) begin
                  result_r <= code;
                  state_r <= `ADCQ_ST_SLEEP;
               end
            end
            `ADCQ_ST_SLEEP: begin
               if (phase_r == `ADCQ_PH_ACKP && sclFall) begin
                  state_r <= `ADCQ_ST_OUT;
               end
            end
            `ADCQ_ST_OUT: begin
               if ((stopCond && validRead_r) ||
                   (phase_r == `ADCQ_PH_TX && sclFall && byteSel_r &&
                    bitCnt_r == `ADCQ_BITS_PER_BYTE)) begin
                  state_r <= `ADCQ_ST_CONV;
                  convKick_r <= 1'b1;
                  validRead_r <= 1'b0;
               end
            end
            default: begin
               state_r <= `ADCQ_ST_POR;
            end
         endcase

         // bus engine; START and STOP take priority over bit events
         if (state_r == `ADCQ_ST_POR) begin
            phase_r <= `ADCQ_PH_IDLE;
            sdaOe <= 1'b0;
         end else if (startCond) begin
            phase_r <= `ADCQ_PH_ADDR;
            bitCnt_r <= 4'h0;
            sdaOe <= 1'b0;
         end else if (stopCond) begin
            phase_r <= `ADCQ_PH_IDLE;
            sdaOe <= 1'b0;
         end else begin
            case (phase_r)
               `ADCQ_PH_ADDR: begin
                  if (sclRise) begin
                     addrSh_r <= {addrSh_r[6:0], sdaS};
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end else if (sclFall &&
                               bitCnt_r == `ADCQ_BITS_PER_BYTE) begin
                     if (addrHit && readReady) begin
                        sdaOe <= 1'b1;
                        phase_r <= `ADCQ_PH_ACKP;
                        txSh_r <= result_r;
                        byteSel_r <= 1'b0;
                        validRead_r <= 1'b1;
                     end else begin
                        phase_r <= `ADCQ_PH_IGN;
                     end
                  end
               end
               `ADCQ_PH_ACKP: begin
                  if (sclFall) begin
                     sdaOe <= ~txSh_r[15];
                     txSh_r <= {txSh_r[14:0], 1'b0};
                     bitCnt_r <= 4'h1;
                     phase_r <= `ADCQ_PH_TX;
                  end
               end
               `ADCQ_PH_ACKD: begin
                  if (sclFall) begin
                     sdaOe <= ~txSh_r[15];
                     txSh_r <= {txSh_r[14:0], 1'b0};
                     bitCnt_r <= 4'h1;
                     phase_r <= `ADCQ_PH_TX;
                  end
               end
               `ADCQ_PH_TX: begin
                  if (sclFall) begin
                     if (bitCnt_r == `ADCQ_BITS_PER_BYTE) begin
                        sdaOe <= 1'b0;
                        phase_r <= byteSel_r ? `ADCQ_PH_IGN :
                           `ADCQ_PH_MACK;
                     end else begin
                        sdaOe <= ~txSh_r[15];
                        txSh_r <= {txSh_r[14:0], 1'b0};
                        bitCnt_r <= bitCnt_r + 4'h1;
                     end
                  end
               end
               `ADCQ_PH_MACK: begin
                  if (sclRise) begin
                     if (!sdaS) begin
                        byteSel_r <= 1'b1;
                        phase_r <= `ADCQ_PH_ACKD;
                     end else begin
                        phase_r <= `ADCQ_PH_IGN;
                     end
                  end
               end
               `ADCQ_PH_IGN: begin
                  sdaOe <= 1'b0;
               end
               `ADCQ_PH_IDLE: begin
                  sdaOe <= 1'b0;
               end
               default: begin
                  phase_r <= `ADCQ_PH_IDLE;
                  sdaOe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** hdl/adcq_map.vh ***
// Summary of operation
// - cycle conversion, sleep, data output, repeat
// - finished conversion enters low-power sleep
// - sleep holds result until addressed for read
// - address during conversion gets NAK
// - answer only fixed address 0010100
// - read after conversion is ACKed, output begins
// - result is sixteen bits: sign plus fifteen
// - bit changes after SCL fall, sampled rising
// - STOP after read or 16 bits restarts conversion
// - half-millisecond internal reset, then conversion
// - code is 32768 times ratio, clamped
// - sign first, then magnitude MSB down to LSB
// - offset calibration inside every conversion
// - one result per conversion, no latency
// - repeated START reads without new conversion
// - eight data bits then one acknowledge slot
// - SDA changes only while SCL low
// - slave only, SCL input, transmit only
// - SDA only pulled low or released
// - works up to 400 kbit/s fast mode
// - SDA released except ACK and data output
`ifndef ADCQ_MAP_VH
`define ADCQ_MAP_VH

`define ADCQ_CLK_KHZ 25000
`define ADCQ_POR_US 500
`define ADCQ_CONV_US 16600
`define ADCQ_US_PER_MS 1000

`define ADCQ_SLAVE_ADDR 7'h14
`define ADCQ_READ_BIT 1'b1

`define ADCQ_ST_POR 2'h0
`define ADCQ_ST_CONV 2'h1
`define ADCQ_ST_SLEEP 2'h2
`define ADCQ_ST_OUT 2'h3

`define ADCQ_PH_IDLE 3'h0
`define ADCQ_PH_ADDR 3'h1
`define ADCQ_PH_ACKP 3'h2
`define ADCQ_PH_ACKD 3'h3
`define ADCQ_PH_TX 3'h4
`define ADCQ_PH_MACK 3'h5
`define ADCQ_PH_IGN 3'h6

`define ADCQ_BITS_PER_BYTE 4'h8
`define ADCQ_SIGN_FLIP 16'h8000
`define ADCQ_CODE_MAX 16'h7fff
`define ADCQ_CODE_MIN 16'h8000
`define ADCQ_RAW_W 18
`define ADCQ_TMR_W 24

`endif

// *** hdl/adcq_sync.v ***
`timescale 1ns/1ns
`default_nettype none
module adcq_sync #(
   parameter W = 2
) (
   input wire mclk,
   input wire rst,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_r;

   // two stages; idle bus lines read high
   always @(posedge mclk) begin
      if (rst) begin
         meta_r <= {W{1'b1}};
         q <= {W{1'b1}};
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// *** hdl/adcq_timer.v ***
`timescale 1ns/1ns
`default_nettype none
`include "adcq_map.vh"
module adcq_timer #(
   parameter [`ADCQ_TMR_W-1:0] CYCLES = 24'h000010
) (
   input wire mclk,
   input wire rst,
   input wire start,
   output reg busy,
   output reg done
);
   reg [`ADCQ_TMR_W-1:0] cnt_r;

   // one-shot interval; done pulses one cycle at the end
   always @(posedge mclk) begin
      if (rst) begin
         cnt_r <= {`ADCQ_TMR_W{1'b0}};
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_r <= CYCLES - 24'h000001;
            busy <= 1'b1;
         end else if (busy) begin
            if (cnt_r == {`ADCQ_TMR_W{1'b0}}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 24'h000001;
            end
         end
      end
   end
endmodule
`default_nettype wire
